// >>> design/plc_ctrl_pkg.sv
// shared constants and carrier types for the host control register bank
package plc_ctrl_pkg;

    // register offsets on the host register port
    localparam logic [6:0] OFF_IRQ_CONTROL = 7'h00;
    localparam logic [6:0] OFF_LINK_MODE = 7'h05;
    localparam logic [6:0] OFF_TRANSMIT_LAUNCH = 7'h06;
    localparam logic [6:0] OFF_IRQ_STATUS = 7'h69;

    // irq_control_reg fields
    localparam int IRQ_ACK_BIT = 7;
    localparam int IRQ_POL_BIT = 6;

    // transmit_launch_reg fields
    localparam int SEND_BIT = 7;
    localparam int LEN_MSB = 4;

    // irq status register fields that are not event bits
    localparam int STAT_CHANGED_BIT = 7;
    localparam int STAT_BUSY_BIT = 5;

    // event indices, equal to their enable bit positions in irq_control_reg
    localparam int EV_SENT = 0;
    localparam int EV_DATA = 1;
    localparam int EV_DROP = 2;
    localparam int EV_NO_RESP = 3;
    localparam int EV_NO_ACK = 4;
    localparam int EV_CANNOT_SEND = 5;
    localparam int NUM_EV = 6;

    // pending bits that survive a host acknowledge
    localparam logic [5:0] ACK_KEEP_MASK = 6'h06;

    // values after reset
    localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
    localparam logic [7:0] LINK_MODE_RST = 8'hc0;
    localparam logic [4:0] PAYLOAD_LEN_RST = 5'h00;

    // link mode bits, msb first in register order
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic lock;
        logic carrier_sense_off;
        logic rx_overwrite;
        logic ext_addr;
        logic addr_filter_bypass;
        logic crc_bypass;
    } link_ctrl_t;

    // one host register transaction, already decoded from the serial link
    typedef struct packed {
        logic we;
        logic re;
        logic [6:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // status events and levels from the protocol engine
    typedef struct packed {
        logic tx_sent;
        logic tx_no_resp;
        logic tx_no_ack;
        logic carrier_timeout;
        logic tx_done;
        logic rx_consumed;
        logic ack_mode;
    } engine_events_t;

    // remote configuration change request arriving over the line
    typedef struct packed {
        logic valid;
        logic tx_enable;
        logic ext_addr;
        logic carrier_sense_off;
    } remote_cfg_t;

    // a received frame as judged by the physical and framing layers
    typedef struct packed {
        logic valid;
        logic is_ack;
        logic addr_match;
        logic crc_ok;
    } rx_frame_t;

    // what happens to a received frame
    typedef struct packed {
        logic accept;
        logic replace;
        logic drop;
    } rx_verdict_t;

    // transmit launch states
    typedef enum logic [1:0] {
        LAUNCH_IDLE = 2'b01,
        LAUNCH_BUSY = 2'b10
    } launch_state_t;

endpackage : plc_ctrl_pkg

// >>> design/rx_gate.sv
// receive acceptance filter: mode, address, crc and buffer-full policy
`timescale 1ns/1ps
module rx_gate (
    input wire logic clk_sys,
    input wire logic rst_n,
    input plc_ctrl_pkg::link_ctrl_t mode,
    input plc_ctrl_pkg::rx_frame_t frame,
    input wire logic buf_full,
    output plc_ctrl_pkg::rx_verdict_t verdict
);
    import plc_ctrl_pkg::*;

    // whole state of the filter
    typedef struct packed {
        rx_verdict_t verdict;
    } gate_state_t;

    gate_state_t s_reg; // registered state
    gate_state_t s_next; // next state

    // verdict per frame, one-cycle pulses
    always_comb begin
        logic pass_addr;
        logic pass_crc;
        logic mode_ok;
        pass_addr = frame.addr_match | mode.addr_filter_bypass;
        pass_crc = frame.crc_ok | mode.crc_bypass;
        mode_ok = mode.rx_enable | frame.is_ack;
        s_next = s_reg;
        s_next.verdict = '0;
        if (frame.valid && pass_addr && pass_crc && mode_ok) begin
            if (frame.is_ack || !buf_full) begin
                // acks never occupy the receive buffer
                s_next.verdict.accept = 1'b1;
            end else if (mode.rx_overwrite) begin
                s_next.verdict.replace = 1'b1;
            end else begin
                s_next.verdict.drop = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign verdict = s_reg.verdict;

endmodule : rx_gate

// >>> design/plc_host_control_regs.sv
// host control registers: interrupt logic, link mode and transmit launch
//
// Functional notes
// - irq fires sets ack bit; write 0 clears status; here data and dropped bits survive it
// - pin active high if polarity 0, else low
// - carrier-sense timeout irq, only while sensing on
// - missing-ack irq only in acknowledged service mode
// - missing-reply irq when enabled
// - dropped-packet irq when receive buffer full
// - pending change forces irq on drop or arrival
// - new-data irq when enabled
// - sent-ok irq when enabled
// - transmit disabled: only acknowledgments go out
// - receive disabled: only acknowledgments accepted
// - lock bit refuses remote configuration changes
// - carrier sense before transmit unless disabled
// - buffer full: drop or overwrite per bit
// - extended bit picks 16-bit over 8-bit addressing
// - filter bypass accepts any crc-good message
// - crc bypass accepts address-matching messages
// - send bit starts transmit, self-clears when done
// - five-bit payload length, 0 to 31
`timescale 1ns/1ps
module plc_host_control_regs (
    input wire logic clk_sys,
    input wire logic rst_n,
    input plc_ctrl_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    input plc_ctrl_pkg::engine_events_t engine_ev,
    input plc_ctrl_pkg::remote_cfg_t remote_cfg,
    input plc_ctrl_pkg::rx_frame_t rx_frame,
    input wire logic rx_buf_full,
    output plc_ctrl_pkg::rx_verdict_t rx_verdict,
    output plc_ctrl_pkg::link_ctrl_t link_ctrl,
    output logic tx_start,
    output logic [4:0] tx_payload_len,
    output logic tx_normal_ok,
    output logic sense_before_tx,
    output logic addr_16bit,
    output logic remote_change_ok,
    output logic host_irq
);
    import plc_ctrl_pkg::*;

    // register map, one byte per offset:
    //   0x00 irq control: ack flag, polarity, six enables
    //   0x05 link mode, msb first: tx enable, rx enable, lock,
    //        sense off, overwrite, wide address, two filter bypasses
    //   0x06 launch: send, two zero bits, five-bit length
    //   0x69 status, read only: changed, 0, busy, five pending
    //   other offsets read zero and ignore writes
    //
    // a write lands at the edge that samples it; a read answers at that
    // same edge with a one-cycle valid, and the data then holds
    //
    // engine pulses reach the pin at the edge that samples them; receive
    // events take one cycle more through the filter
    //
    // a send write while busy is dropped, its length still stored
    //
    // limitation: cannot-send has no status bit; the host sees it
    // only through the pin and the changed flag

    ////////////////////////////////////////////////////////////////////////////

    // one struct holds every flop, so reset and
    // next-state logic cannot drift apart
    // whole state of the register bank
    typedef struct packed {
        logic [7:0] irq_control_reg; // ack flag, polarity, six enables
        link_ctrl_t link_mode_reg; // link mode bits
        launch_state_t launch; // idle or transmitting
        logic [4:0] payload_len; // payload length field
        logic [NUM_EV-1:0] pending; // sticky status events
        logic changed; // status-changed flag
        logic forced; // irq raised regardless of enables
        logic irq_level; // irq before polarity
        logic irq_pin; // pin level after polarity
        logic [7:0] rdata; // read data
        logic rvalid; // read strobe
        logic start; // transmit start pulse
        logic tx_ok; // normal transmit allowed
        logic sense_on; // carrier sense in use
        logic addr16; // wide addressing in use
        logic remote_ok; // remote changes allowed
    } ctl_state_t;

    ctl_state_t s_reg; // registered state
    ctl_state_t s_next; // next state
    rx_verdict_t verdict; // receive filter result, already registered

    // only the address is compared here; each caller
    // qualifies it with the strobe it cares about
    // address compare shared by write and read decode
    function automatic logic hit(input host_req_t req, input logic [6:0] off);
        hit = (req.addr == off);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////

    // receive acceptance filter
    // it reads the registered mode, so a mode write
    // applies to frames arriving after it lands
    rx_gate u_rx_gate (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mode(s_reg.link_mode_reg),
        .frame(rx_frame),
        .buf_full(rx_buf_full),
        .verdict(verdict)
    );

    ////////////////////////////////////////////////////////////////////////////

    // next-state logic for the whole bank
    always_comb begin
        logic [NUM_EV-1:0] ev;
        logic [7:0] rd;
        logic level;
        // locals start at known values
        ev = '0;
        rd = 8'h00;
        level = 1'b0;
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.start = 1'b0;
        // strobes above pulse once; all else holds

        // collect events of this cycle
        // each is a one-cycle pulse; pending holds them
        ev[EV_SENT] = engine_ev.tx_sent;
        // an overwrite is still new data for the host
        ev[EV_DATA] = verdict.accept | verdict.replace;
        ev[EV_DROP] = verdict.drop;
        ev[EV_NO_RESP] = engine_ev.tx_no_resp;
        // a missing ack means nothing outside ack mode
        ev[EV_NO_ACK] = engine_ev.tx_no_ack & engine_ev.ack_mode;
        // timeout only counts while sensing is on
        ev[EV_CANNOT_SEND] = engine_ev.carrier_timeout
            & ~s_reg.link_mode_reg.carrier_sense_off;

        // clears first, so that an event in the same cycle still lands
        if (host_req.we && hit(host_req, OFF_IRQ_CONTROL)) begin
            s_next.irq_control_reg[IRQ_POL_BIT:0] = host_req.wdata[IRQ_POL_BIT:0];
            // a write of 1 never sets the ack flag; only an
            // interrupt does, so read-modify-write is safe
            if (!host_req.wdata[IRQ_ACK_BIT]) begin
                // data-available and dropped survive the acknowledge
                s_next.pending = s_reg.pending & ACK_KEEP_MASK;
                s_next.irq_control_reg[IRQ_ACK_BIT] = 1'b0;
                // the changed flag and forced term go with it
                s_next.changed = 1'b0;
                s_next.forced = 1'b0;
            end
        end

        if (engine_ev.rx_consumed) begin
            // host emptied the receive buffer
            // an acknowledge alone cannot clear these two
            s_next.pending[EV_DATA] = 1'b0;
            s_next.pending[EV_DROP] = 1'b0;
        end

        // an unacknowledged change forces the pin on drop or arrival
        // it ignores the enables on purpose and stays until the
        // host acknowledges, so a slow host cannot miss an arrival
        if (s_reg.changed && (ev[EV_DROP] || ev[EV_DATA])) begin
            s_next.forced = 1'b1;
        end
        // set wins: events are or-ed in after every clear above
        s_next.pending = s_next.pending | ev;
        // changed marks any event since the last acknowledge
        if (|ev) begin
            s_next.changed = 1'b1;
        end

        // pin level: or of enabled pending events plus the forced term
        // next-state values are used so the pin follows an event
        // or a clear at the same edge instead of one cycle late
        level = (|(s_next.pending & s_next.irq_control_reg[NUM_EV-1:0]))
            | s_next.forced;
        // kept to find the rising edge of the level
        s_next.irq_level = level;
        if (level && !s_reg.irq_level) begin
            s_next.irq_control_reg[IRQ_ACK_BIT] = 1'b1;
        end
        // polarity applied before the flop, so the pin never glitches
        s_next.irq_pin = level ^ s_next.irq_control_reg[IRQ_POL_BIT];

        // remote changes apply first so a host write in the same cycle wins
        // only the three fields a remote node may touch are carried;
        // the rest of the link mode is under host control alone
        if (remote_cfg.valid && !s_reg.link_mode_reg.lock) begin
            s_next.link_mode_reg.tx_enable = remote_cfg.tx_enable;
            s_next.link_mode_reg.ext_addr = remote_cfg.ext_addr;
            s_next.link_mode_reg.carrier_sense_off = remote_cfg.carrier_sense_off;
        end
        // a host write replaces the whole link mode byte
        if (host_req.we && hit(host_req, OFF_LINK_MODE)) begin
            s_next.link_mode_reg = link_ctrl_t'(host_req.wdata);
        end

        // transmit launch state machine
        // one-hot codes; a stray code falls to default
        case (s_reg.launch)
            LAUNCH_IDLE: begin
                // a send write starts one transmission
                if (host_req.we && hit(host_req, OFF_TRANSMIT_LAUNCH)
                        && host_req.wdata[SEND_BIT]) begin
                    s_next.launch = LAUNCH_BUSY;
                    s_next.start = 1'b1;
                end
            end
            LAUNCH_BUSY: begin
                // writes of the send bit while busy are ignored
                if (engine_ev.tx_done) begin
                    s_next.launch = LAUNCH_IDLE;
                end
            end
            default: begin
                // unreachable, recover to idle
                s_next.launch = LAUNCH_IDLE;
            end
        endcase

        // length is stored even when the launch is refused
        if (host_req.we && hit(host_req, OFF_TRANSMIT_LAUNCH)) begin
            s_next.payload_len = host_req.wdata[LEN_MSB:0];
        end

        // derived link policy levels
        // registered copies keep outputs straight from flops
        s_next.tx_ok = s_next.link_mode_reg.tx_enable;
        s_next.sense_on = ~s_next.link_mode_reg.carrier_sense_off;
        s_next.addr16 = s_next.link_mode_reg.ext_addr;
        s_next.remote_ok = ~s_next.link_mode_reg.lock;

        // read decode, unmapped offsets read as zero
        // reads see registered state, not this cycle's write
        if (hit(host_req, OFF_IRQ_CONTROL)) begin
            rd = s_reg.irq_control_reg;
        end else if (hit(host_req, OFF_LINK_MODE)) begin
            rd = s_reg.link_mode_reg;
        end else if (hit(host_req, OFF_TRANSMIT_LAUNCH)) begin
            rd = {(s_reg.launch == LAUNCH_BUSY), 2'b00, s_reg.payload_len};
        end else if (hit(host_req, OFF_IRQ_STATUS)) begin
            // bit 6 is reserved and reads zero
            rd = {3'b000, s_reg.pending[EV_NO_ACK:0]};
            rd[STAT_CHANGED_BIT] = s_reg.changed;
            rd[STAT_BUSY_BIT] = (s_reg.launch == LAUNCH_BUSY);
        end else begin
            rd = 8'h00;
        end

        // rdata moves only on a read, so it holds meanwhile
        if (host_req.re) begin
            s_next.rdata = rd;
            s_next.rvalid = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // state register, constants only under reset
    // fields without a listed reset value start at zero
    // from the clearing assignment; launch must start
    // idle because zero is not a legal one-hot code
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.irq_control_reg <= IRQ_CONTROL_RST;
            s_reg.link_mode_reg <= link_ctrl_t'(LINK_MODE_RST);
            s_reg.launch <= LAUNCH_IDLE;
            s_reg.payload_len <= PAYLOAD_LEN_RST;
            s_reg.tx_ok <= 1'b1;
            s_reg.sense_on <= 1'b1;
            s_reg.remote_ok <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // outputs straight from state flops
    // nothing here is decoded, so no output glitches
    assign host_rdata = s_reg.rdata;
    assign host_rvalid = s_reg.rvalid;
    assign rx_verdict = verdict;
    assign link_ctrl = s_reg.link_mode_reg;
    assign tx_start = s_reg.start;
    assign tx_payload_len = s_reg.payload_len;
    assign tx_normal_ok = s_reg.tx_ok;
    assign sense_before_tx = s_reg.sense_on;
    assign addr_16bit = s_reg.addr16;
    assign remote_change_ok = s_reg.remote_ok;
    assign host_irq = s_reg.irq_pin;

endmodule : plc_host_control_regs

// >>> tb/plc_regs_checker.sv
// port assertions for the host control register bank
`timescale 1ns/1ps
module plc_regs_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input plc_ctrl_pkg::host_req_t host_req,
    input plc_ctrl_pkg::remote_cfg_t remote_cfg,
    input plc_ctrl_pkg::rx_frame_t rx_frame,
    input wire logic rx_buf_full,
    input plc_ctrl_pkg::rx_verdict_t rx_verdict,
    input plc_ctrl_pkg::link_ctrl_t link_ctrl,
    input wire logic [4:0] tx_payload_len,
    input wire logic tx_normal_ok,
    input wire logic sense_before_tx,
    input wire logic addr_16bit
);
    import plc_ctrl_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // good non-ack frame meeting a full buffer
    sequence full_hit_s;
        rx_frame.valid && !rx_frame.is_ack && rx_frame.addr_match && rx_frame.crc_ok
            && rx_buf_full && link_ctrl.rx_enable;
    endsequence
    // remote request with no host write racing it
    sequence remote_only_s;
        remote_cfg.valid && !(host_req.we && host_req.addr == OFF_LINK_MODE);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_tx_gate: assert property (tx_normal_ok == link_ctrl.tx_enable)
        else $error("tx gate wrong");
    chk_sense_gate: assert property (sense_before_tx == !link_ctrl.carrier_sense_off)
        else $error("sense gate wrong");
    chk_addr_width: assert property (addr_16bit == link_ctrl.ext_addr)
        else $error("addr width wrong");
    chk_lock_refuse: assert property (remote_only_s ##0 link_ctrl.lock |=> $stable(link_ctrl))
        else $error("locked mode changed");
    chk_remote_take: assert property (remote_only_s ##0 !link_ctrl.lock |=>
        link_ctrl.tx_enable == $past(remote_cfg.tx_enable)) else $error("remote ignored");
    chk_drop_full: assert property (full_hit_s ##0 !link_ctrl.rx_overwrite |=> rx_verdict.drop)
        else $error("no drop");
    chk_replace_full: assert property (full_hit_s ##0 link_ctrl.rx_overwrite |=>
        rx_verdict.replace && !rx_verdict.drop) else $error("no replace");
    chk_rx_off: assert property (rx_frame.valid && !rx_frame.is_ack && !link_ctrl.rx_enable
        |=> rx_verdict == '0) else $error("rx off took frame");
    chk_addr_filter: assert property (rx_frame.valid && !rx_frame.is_ack
        && !rx_frame.addr_match && !link_ctrl.addr_filter_bypass |=> !rx_verdict.accept)
        else $error("addr filter open");
    chk_crc_filter: assert property (rx_frame.valid && !rx_frame.is_ack
        && !rx_frame.crc_ok && !link_ctrl.crc_bypass |=> !rx_verdict.accept)
        else $error("crc filter open");
    chk_len_take: assert property (host_req.we && host_req.addr == OFF_TRANSMIT_LAUNCH
        |=> tx_payload_len == $past(host_req.wdata[4:0])) else $error("length not taken");
endmodule : plc_regs_checker

bind plc_host_control_regs plc_regs_checker chk_u (.clk_sys, .rst_n, .host_req,
    .remote_cfg, .rx_frame, .rx_buf_full, .rx_verdict, .link_ctrl, .tx_payload_len,
    .tx_normal_ok, .sense_before_tx, .addr_16bit);

// >>> tb/host_model.sv
// host microcontroller model: single byte register reads and writes
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    output plc_ctrl_pkg::host_req_t host_req,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid
);
    import plc_ctrl_pkg::*;
    initial host_req = '0;
    // send_lead_delay per bit rate is kept by the host outside this bank
    // write held for one sampling edge; released fields scrambled
    task automatic wr(input logic [6:0] a, input logic [7:0] w);
        @(posedge clk_sys);
        host_req <= {2'b10, a, w};
        @(posedge clk_sys);
        host_req <= {2'b00, ~a, ~w};
    endtask : wr
    // read: answer taken at the falling edge after the sampling edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        host_req <= {2'b01, a, 8'h5a};
        @(posedge clk_sys);
        host_req <= {2'b00, ~a, 8'ha5};
        @(negedge clk_sys);
        d = host_rdata;
        v = host_rvalid;
    endtask : rd
endmodule : host_model

// >>> tb/testbench.sv
// self-checking bench for the host control register bank
`timescale 1ns/1ps
module testbench;
    import plc_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    host_req_t host_req;
    engine_events_t engine_ev = '0;
    remote_cfg_t remote_cfg = '0;
    rx_frame_t rx_frame = '0;
    rx_verdict_t rx_verdict;
    link_ctrl_t link_ctrl;
    logic [7:0] host_rdata, d;
    logic [4:0] tx_payload_len;
    logic [2:0] exp_v;
    logic [31:0] st = 32'd84, r;
    logic rx_buf_full = 1'b0, ack_mode = 1'b1, v, host_rvalid, tx_start, host_irq;
    logic tx_normal_ok, sense_before_tx, addr_16bit, remote_change_ok;
    int miscompares = 0, tests_run = 0, starts = 0, n0;
    logic [6:0] evb [4] = '{7'h40, 7'h20, 7'h10, 7'h08}; // sent, no reply, no ack, timeout
    int enb [4] = '{EV_SENT, EV_NO_RESP, EV_NO_ACK, EV_CANNOT_SEND};
    plc_host_control_regs dut_u (.clk_sys, .rst_n, .host_req, .host_rdata, .host_rvalid,
        .engine_ev, .remote_cfg, .rx_frame, .rx_buf_full, .rx_verdict, .link_ctrl, .tx_start,
        .tx_payload_len, .tx_normal_ok, .sense_before_tx, .addr_16bit, .remote_change_ok,
        .host_irq);
    host_model host_u (.clk_sys, .host_req, .host_rdata, .host_rvalid);
    ////////////////////////////////////////////////////////////////////////
    initial forever #2.5 clk_sys = ~clk_sys;
    // launch pulses counted where settled, so a double pulse shows
    always @(negedge clk_sys) if (tx_start === 1'b1) starts++;
    function automatic logic [31:0] xs();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : xs
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string n);
        host_u.rd(a, d, v);
        chk(n, e, d);
        chk("rvalid", 8'h01, {7'h0, v});
    endtask : rdc
    // let n edges pass, then look where outputs are settled
    task automatic sett(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : sett
    task automatic pulse(input logic [6:0] e);
        @(posedge clk_sys);
        engine_ev <= e | {6'h0, ack_mode};
        @(posedge clk_sys);
        engine_ev <= {6'h0, ack_mode};
    endtask : pulse
    task automatic frm(input logic [3:0] f, input logic full);
        @(posedge clk_sys);
        rx_frame <= f;
        rx_buf_full <= full;
        @(posedge clk_sys);
        rx_frame <= {1'b0, ~f[2:0]};
        @(negedge clk_sys);
    endtask : frm
    task automatic rem(input logic [2:0] c);
        @(posedge clk_sys);
        remote_cfg <= {1'b1, c};
        @(posedge clk_sys);
        remote_cfg <= {1'b0, ~c};
        @(negedge clk_sys);
    endtask : rem
    task automatic stop_test;
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // run needs some 380 cycles; cut off at 20000 cycles, well past that
    initial begin
        #100000;
        miscompares++;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk("link_ctrl", 8'hc0, link_ctrl);
        rdc(OFF_IRQ_CONTROL, 8'h00, "irq_control");
        rdc(OFF_LINK_MODE, 8'hc0, "link_mode");
        rdc(OFF_TRANSMIT_LAUNCH, 8'h00, "launch");
        rdc(7'h7f, 8'h00, "unmapped");
        // sent, no reply, no ack and timeout sources, both pin polarities
        for (int p = 0; p < 2; p++) for (int i = 0; i < 4; i++) begin
            host_u.wr(OFF_IRQ_CONTROL, 8'(p << 6) | 8'(1 << enb[i]));
            sett(1);
            chk("irq idle", 8'(p), {7'h0, host_irq});
            pulse(evb[i]);
            sett(0);
            chk("irq set", 8'(1 - p), {7'h0, host_irq});
            rdc(OFF_IRQ_CONTROL, 8'h80 | 8'(p << 6) | 8'(1 << enb[i]), "ack");
            rdc(OFF_IRQ_STATUS, (i == 3) ? 8'h80 : 8'h80 | 8'(1 << enb[i]), "status");
            host_u.wr(OFF_IRQ_CONTROL, 8'(p << 6));
            sett(1);
            chk("irq clear", 8'(p), {7'h0, host_irq});
        end
        // no ack outside ack mode, timeout with sensing off: both ignored
        ack_mode = 1'b0;
        host_u.wr(OFF_IRQ_CONTROL, 8'h30);
        host_u.wr(OFF_LINK_MODE, 8'hd0);
        pulse(7'h18);
        sett(1);
        chk("irq refused", 8'h00, {7'h0, host_irq});
        chk("sense", 8'h00, {7'h0, sense_before_tx});
        ack_mode = 1'b1;
        host_u.wr(OFF_LINK_MODE, 8'hc0);
        host_u.wr(OFF_IRQ_CONTROL, 8'h00);
        pulse(7'h40);
        frm(4'hb, 1'b0);
        sett(1);
        chk("irq forced", 8'h01, {7'h0, host_irq});
        host_u.wr(OFF_IRQ_CONTROL, 8'h02);
        sett(1);
        chk("irq data", 8'h01, {7'h0, host_irq});
        pulse(7'h02);
        sett(1);
        chk("irq consumed", 8'h00, {7'h0, host_irq});
        host_u.wr(OFF_IRQ_CONTROL, 8'h04);
        frm(4'hb, 1'b1);
        chk("drop", 8'h01, {5'h0, rx_verdict});
        sett(0);
        chk("irq drop", 8'h01, {7'h0, host_irq});
        pulse(7'h02);
        host_u.wr(OFF_IRQ_CONTROL, 8'h00);
        // random modes and frames against the filter model
        for (int k = 0; k < 40; k++) begin
            r = xs();
            host_u.wr(OFF_LINK_MODE, {1'b1, r[0], 2'b00, r[1], r[7], r[2], r[3]});
            frm({2'b10, r[4], r[5] | ~r[4]}, r[6]);
            exp_v = 3'b000;
            if (r[0] && (r[4] || r[2]) && (r[5] || ~r[4] || r[3]))
                exp_v = r[6] ? (r[1] ? 3'b010 : 3'b001) : 3'b100;
            chk("verdict", {5'h0, exp_v}, {5'h0, rx_verdict});
            chk("addr16", {7'h0, r[7]}, {7'h0, addr_16bit});
        end
        host_u.wr(OFF_LINK_MODE, 8'hc8);
        frm(4'hb, 1'b1);
        chk("replace", 8'h02, {5'h0, rx_verdict});
        pulse(7'h02);
        host_u.wr(OFF_LINK_MODE, 8'h80);
        frm(4'hf, 1'b0);
        chk("ack frame", 8'h04, {5'h0, rx_verdict});
        pulse(7'h02);
        host_u.wr(OFF_LINK_MODE, 8'hc0);
        rem(3'b011);
        chk("remote", 8'h54, link_ctrl);
        chk("tx ok", 8'h00, {7'h0, tx_normal_ok});
        host_u.wr(OFF_LINK_MODE, 8'he0);
        rem(3'b011);
        chk("locked", 8'h00, {7'h0, remote_change_ok});
        chk("locked mode", 8'he0, link_ctrl);
        // launches at both length limits, a refused relaunch while busy
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 32'd0 : (i == 1) ? 32'd31 : xs();
            n0 = starts;
            host_u.wr(OFF_TRANSMIT_LAUNCH, {3'b100, r[4:0]});
            sett(1);
            chk("starts", 8'(n0 + 1), 8'(starts));
            rdc(OFF_TRANSMIT_LAUNCH, {3'b100, r[4:0]}, "busy");
            host_u.wr(OFF_TRANSMIT_LAUNCH, {3'b100, ~r[4:0]});
            sett(1);
            chk("len", {3'b0, ~r[4:0]}, {3'b0, tx_payload_len});
            pulse(7'h04);
            rdc(OFF_TRANSMIT_LAUNCH, {3'b000, ~r[4:0]}, "idle");
            chk("one start", 8'(n0 + 1), 8'(starts));
        end
        stop_test;
    end
endmodule : testbench
